// ---- pss_regs.svh ----
// Bit positions, parameter digit codes and timing counts of the positioning start sequencer
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

// Parameter digit positions (four hex digits per 16-bit parameter word)
`define PSS_OPSYS_LSB 0
`define PSS_SIGN_LSB 8
`define PSS_STROBE_LSB 12
`define PSS_CMDSYS_LSB 0
`define PSS_DIGIT_W 4

// Digit codes
`define PSS_OPSYS_BCD 4'h2
`define PSS_STROBE_USED 4'h0
`define PSS_SIGN_ON 4'h1
`define PSS_CMDSYS_ABS 4'h0
`define PSS_CMDSYS_INC 4'h1
`define PSS_JOG_TABLE 4'h1
`define PSS_NO_TABLE 4'h0

// Filtered input vector layout
`define PSS_IN_FWD 0
`define PSS_IN_REV 1
`define PSS_IN_PAUSE 2
`define PSS_IN_DATA_STROBE_IN 3
`define PSS_IN_AUTO 4
`define PSS_IN_PSEL_LSB 5
`define PSS_IN_TNUM_LSB 9
`define PSS_IN_BCD_LSB 17
`define PSS_IN_SIGN 41
`define PSS_IN_COUNT 42

// Timing
`define PSS_CLK_PERIOD_NS 25
`define PSS_FILT_UNIT_NS 1000000
`define PSS_FILT_UNIT_CYC ((`PSS_FILT_UNIT_NS + `PSS_CLK_PERIOD_NS - 1) / `PSS_CLK_PERIOD_NS)

`endif

// ---- pss_pkg.sv ----
// Types shared by the positioning start sequencer
package pss_pkg;

	typedef enum logic [2:0] {
		PSS_IDLE = 3'b000,
		PSS_MOVE = 3'b001,
		PSS_STOPPING = 3'b010,
		PSS_PAUSED = 3'b011,
		PSS_JOG = 3'b100
	} pss_state_t;

	// Command to the motion core
	typedef struct packed {
		logic startPulse;
		logic resumePulse;
		logic pausePulse;
		logic discardPulse;
		logic jogRun;
		logic ccw;
		logic absolute;
		logic negative;
		logic [23:0] distanceBcd;
		logic [3:0] tableSel;
		logic speedFromJog;
		logic [15:0] jogSpeed;
	} pss_cmd_t;

endpackage : pss_pkg

// ---- pss_sequencer.sv ----
// Positioning start sequencer: input filtering, BCD start, pause/resume and jog
`timescale 1ns/100ps
`include "pss_regs.svh"

module pss_sequencer
	import pss_pkg::*;
#(
	parameter int FILT_UNIT_CYC = `PSS_FILT_UNIT_CYC,
	parameter int FILT_CNT_W = 20
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Controller pins
	input wire logic forwardStartIn,
	input wire logic reverseStartIn,
	input wire logic pauseResumeIn,
	input wire logic dataStrobeIn,
	input wire logic autoManualSelectIn,
	input wire logic [3:0] profileSelectIn,
	input wire logic [7:0] tableNumberIn,
	input wire logic [23:0] bcdDataIn,
	input wire logic bcdSignIn,
	// Parameters
	input wire logic [15:0] functionSelectParam,
	input wire logic [15:0] commandSystemParam,
	input wire logic directionSelectParam,
	input wire logic [15:0] jogSpeedParam,
	input wire logic [3:0] inputFilterParam,
	// Motion core
	input wire logic motionDoneIn,
	input wire logic motionStoppedIn,
	output pss_cmd_t cmdOut,
	// Status
	output logic busyOut,
	output logic pausedOut,
	output logic autoModeOut,
	output logic [7:0] tableNumberOut
);

	localparam int NIN = `PSS_IN_COUNT;

	if (FILT_UNIT_CYC < 1 || FILT_CNT_W < 1 || FILT_CNT_W > 31
		|| longint'(15) * longint'(FILT_UNIT_CYC) >= (longint'(1) << FILT_CNT_W))
	begin : g_bad_params
		$error("pss_sequencer: filter parameters out of range");
	end

	logic [NIN-1:0] rawVec;
	logic [NIN-1:0] filtVec;
	logic [FILT_CNT_W-1:0] filtLimit;

	assign rawVec = {bcdSignIn, bcdDataIn, tableNumberIn, profileSelectIn,
		autoManualSelectIn, dataStrobeIn, pauseResumeIn, reverseStartIn, forwardStartIn};
	assign filtLimit = FILT_CNT_W'(32'(inputFilterParam) * FILT_UNIT_CYC);

	// Three-stage synchroniser and debounce per input
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++)
		begin : g_filt
			logic s1Q;
			logic s2Q;
			logic s3Q;
			logic fQ;
			logic [FILT_CNT_W-1:0] cntQ;

			always_ff @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					s1Q <= 1'b0;
					s2Q <= 1'b0;
					s3Q <= 1'b0;
				end
				else
				begin
					s1Q <= rawVec[gi];
					s2Q <= s1Q;
					s3Q <= s2Q;
				end
			end

			always_ff @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					cntQ <= '0;
					fQ <= 1'b0;
				end
				else if (s2Q != s3Q || s3Q == fQ)
					cntQ <= '0;
				else if (cntQ >= filtLimit)
				begin
					fQ <= s3Q;
					cntQ <= '0;
				end
				else
					cntQ <= cntQ + 1'b1;
			end

			assign filtVec[gi] = fQ;
		end
	endgenerate

	logic fwdF;
	logic revF;
	logic pauseF;
	logic strbF;
	logic autoF;
	logic [3:0] pselF;
	logic [23:0] bcdF;
	logic signF;

	assign fwdF = filtVec[`PSS_IN_FWD];
	assign revF = filtVec[`PSS_IN_REV];
	assign pauseF = filtVec[`PSS_IN_PAUSE];
	assign strbF = filtVec[`PSS_IN_DATA_STROBE_IN];
	assign autoF = filtVec[`PSS_IN_AUTO];
	assign pselF = filtVec[`PSS_IN_PSEL_LSB +: 4];
	assign bcdF = filtVec[`PSS_IN_BCD_LSB +: 24];
	assign signF = filtVec[`PSS_IN_SIGN];

	// Previous filtered levels for edge detection
	logic fwdPrevQ;
	logic revPrevQ;
	logic pausePrevQ;
	logic strbPrevQ;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fwdPrevQ <= 1'b0;
			revPrevQ <= 1'b0;
			pausePrevQ <= 1'b0;
			strbPrevQ <= 1'b0;
		end
		else
		begin
			fwdPrevQ <= fwdF;
			revPrevQ <= revF;
			pausePrevQ <= pauseF;
			strbPrevQ <= strbF;
		end
	end

	logic fwdRise;
	logic revRise;
	logic pauseRise;
	logic strbRise;

	assign fwdRise = fwdF & ~fwdPrevQ;
	assign revRise = revF & ~revPrevQ;
	assign pauseRise = pauseF & ~pausePrevQ;
	assign strbRise = strbF & ~strbPrevQ;

	// Parameter decode
	logic bcdEnabled;
	logic strobeUsed;
	logic signUsed;
	logic incremental;

	assign bcdEnabled = functionSelectParam[`PSS_OPSYS_LSB +: `PSS_DIGIT_W]
		== `PSS_OPSYS_BCD;
	assign strobeUsed = functionSelectParam[`PSS_STROBE_LSB +: `PSS_DIGIT_W]
		== `PSS_STROBE_USED;
	assign signUsed = functionSelectParam[`PSS_SIGN_LSB +: `PSS_DIGIT_W]
		== `PSS_SIGN_ON;
	assign incremental = commandSystemParam[`PSS_CMDSYS_LSB +: `PSS_DIGIT_W]
		== `PSS_CMDSYS_INC;

	// Strobe-qualified data holding
	logic [23:0] heldBcdQ;
	logic heldSignQ;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			heldBcdQ <= 24'h000000;
			heldSignQ <= 1'b0;
		end
		else if (strbRise)
		begin
			heldBcdQ <= bcdF;
			heldSignQ <= signF;
		end
	end

	logic [23:0] startBcd;
	logic startSign;

	assign startBcd = strobeUsed ? heldBcdQ : bcdF;
	assign startSign = signUsed & (strobeUsed ? heldSignQ : signF);

	// Start qualification
	logic tableValid;
	logic fwdStart;
	logic revStart;

	assign tableValid = pselF != `PSS_NO_TABLE;
	assign fwdStart = fwdRise & autoF & bcdEnabled & tableValid;
	assign revStart = revRise & ~fwdRise & autoF & bcdEnabled & tableValid
		& incremental;

	// Sequencer
	pss_state_t stateQ;
	pss_state_t stateD;

	always_comb
	begin
		stateD = stateQ;
		unique case (stateQ)
			PSS_IDLE:
			begin
				if (!autoF && (fwdF ^ revF))
					stateD = PSS_JOG;
				else if (fwdStart || revStart)
					stateD = PSS_MOVE;
			end
			PSS_MOVE:
			begin
				if (motionDoneIn)
					stateD = PSS_IDLE;
				else if (pauseRise && autoF)
					stateD = PSS_STOPPING;
			end
			PSS_STOPPING:
			begin
				if (motionDoneIn)
					stateD = PSS_IDLE;
				else if (motionStoppedIn)
					stateD = PSS_PAUSED;
			end
			PSS_PAUSED:
			begin
				if (!autoF)
					stateD = PSS_IDLE;
				else if (pauseRise)
					stateD = PSS_MOVE;
			end
			PSS_JOG:
			begin
				if (autoF || !(fwdF ^ revF))
					stateD = PSS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			stateQ <= PSS_IDLE;
		else
			stateQ <= stateD;
	end

	// Command register
	pss_cmd_t cmdQ;
	logic jogCcw;

	assign jogCcw = fwdF ^ directionSelectParam;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			cmdQ <= '0;
		else
		begin
			cmdQ.startPulse <= 1'b0;
			cmdQ.resumePulse <= 1'b0;
			cmdQ.pausePulse <= 1'b0;
			cmdQ.discardPulse <= 1'b0;
			cmdQ.jogSpeed <= jogSpeedParam;
			if (stateQ == PSS_IDLE && stateD == PSS_MOVE)
			begin
				cmdQ.startPulse <= 1'b1;
				cmdQ.jogRun <= 1'b0;
				cmdQ.speedFromJog <= 1'b0;
				cmdQ.ccw <= fwdStart ^ directionSelectParam;
				cmdQ.absolute <= ~incremental;
				cmdQ.negative <= startSign;
				cmdQ.distanceBcd <= startBcd;
				cmdQ.tableSel <= pselF;
			end
			else if (stateQ == PSS_IDLE && stateD == PSS_JOG)
			begin
				cmdQ.jogRun <= 1'b1;
				cmdQ.speedFromJog <= 1'b1;
				cmdQ.ccw <= jogCcw;
				cmdQ.tableSel <= `PSS_JOG_TABLE;
			end
			else if (stateQ == PSS_JOG && stateD == PSS_IDLE)
				cmdQ.jogRun <= 1'b0;
			else if (stateQ == PSS_MOVE && stateD == PSS_STOPPING)
				cmdQ.pausePulse <= 1'b1;
			else if (stateQ == PSS_PAUSED && stateD == PSS_MOVE)
				cmdQ.resumePulse <= 1'b1;
			else if (stateQ == PSS_PAUSED && stateD == PSS_IDLE)
				cmdQ.discardPulse <= 1'b1;
		end
	end

	assign cmdOut = cmdQ;

	// Status
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			busyOut <= 1'b0;
			pausedOut <= 1'b0;
			autoModeOut <= 1'b0;
			tableNumberOut <= 8'h00;
		end
		else
		begin
			busyOut <= stateD != PSS_IDLE;
			pausedOut <= stateD == PSS_PAUSED;
			autoModeOut <= autoF;
			tableNumberOut <= autoF ? filtVec[`PSS_IN_TNUM_LSB +: 8] : 8'h00;
		end
	end

endmodule : pss_sequencer

// ---- pss_sequencer_props.sv ----
// Port assertions of the positioning start sequencer
`timescale 1ns/100ps
module pss_sequencer_props
	import pss_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Watched ports
	input wire logic [15:0] functionSelectParam,
	input wire logic [15:0] commandSystemParam,
	input wire logic motionDoneIn,
	input wire pss_cmd_t cmdOut,
	input wire logic busyOut,
	input wire logic pausedOut,
	input wire logic autoModeOut,
	input wire logic [7:0] tableNumberOut
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	AST_OPSYS: assert property (cmdOut.startPulse |-> functionSelectParam[3:0] == 4'h2)
		else $error("start without BCD operation system");
	AST_ABS: assert property (cmdOut.startPulse |-> cmdOut.absolute == (commandSystemParam[3:0] != 4'h1))
		else $error("command system flag wrong");
	AST_BUSY: assert property (cmdOut.startPulse |-> busyOut ##1 !cmdOut.startPulse)
		else $error("start pulse not single or not busy");
	AST_TABLE: assert property (cmdOut.startPulse |-> cmdOut.tableSel != 4'h0)
		else $error("start with table zero");
	AST_NOSTART: assert property (pausedOut |-> !cmdOut.startPulse)
		else $error("start while paused");
	AST_MANUAL: assert property (!autoModeOut [*2] |-> tableNumberOut == 8'h00)
		else $error("table number passed in manual");
	AST_JOG: assert property (cmdOut.jogRun |-> cmdOut.tableSel == 4'h1 && cmdOut.speedFromJog)
		else $error("jog without table one");
	AST_DONE: assert property (motionDoneIn && busyOut && !pausedOut && !cmdOut.jogRun |=> !busyOut)
		else $error("busy after move done");
	AST_RESUME: assert property (cmdOut.resumePulse |-> !pausedOut && $past(pausedOut))
		else $error("resume not from pause");
endmodule : pss_sequencer_props

bind pss_sequencer pss_sequencer_props u_props (.clk_sys, .sys_rst, .functionSelectParam,
	.commandSystemParam, .motionDoneIn, .cmdOut, .busyOut, .pausedOut, .autoModeOut,
	.tableNumberOut);

// ---- pss_motion_model.sv ----
// Motion core stand-in answering the sequencer's commands
`timescale 1ns/100ps
module pss_motion_model
	import pss_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Commands and answers
	input wire pss_cmd_t cmdIn,
	input wire logic [15:0] moveLen,
	output logic motionDoneIn,
	output logic motionStoppedIn
);
	logic [15:0] left_q;
	logic run_q;
	logic [1:0] stop_q;
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			left_q <= 16'h0000;
			run_q <= 1'h0;
			stop_q <= 2'h0;
			motionDoneIn <= 1'h0;
			motionStoppedIn <= 1'h0;
		end
		else
		begin
			motionDoneIn <= run_q && left_q == 16'h0001 && !cmdIn.pausePulse;
			motionStoppedIn <= stop_q == 2'h1;
			if (stop_q != 2'h0)
				stop_q <= stop_q - 2'h1;
			if (run_q && left_q != 16'h0000)
				left_q <= left_q - 16'h0001;
			if (run_q && left_q == 16'h0001)
				run_q <= 1'h0;
			if (cmdIn.startPulse)
			begin
				left_q <= moveLen;
				run_q <= 1'h1;
			end
			// Deceleration takes a few cycles
			if (cmdIn.pausePulse)
			begin
				run_q <= 1'h0;
				stop_q <= 2'h3;
			end
			if (cmdIn.resumePulse)
				run_q <= 1'h1;
			if (cmdIn.discardPulse)
				left_q <= 16'h0000;
		end
	end
endmodule : pss_motion_model

// ---- pss_tb.sv ----
// Self-checking bench of the positioning start sequencer
`timescale 1ns/100ps
module tb;
	import pss_pkg::*;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic fwd = 1'h0, rev = 1'h0, pau = 1'h0, data_strobe_in = 1'h0, autoSel = 1'h1, sgn = 1'h0;
	logic dir = 1'h0, done, stopped, busy, paused, autoM, hit;
	logic [3:0] psel = 4'h0, filt = 4'h1;
	logic [7:0] tnum = 8'hA5, tnumOut;
	logic [23:0] bcd = 24'h000000;
	logic [15:0] fsel = 16'h0102, csys = 16'h0001, jogSpd = 16'h1234, moveLen = 16'h0014;
	pss_cmd_t cmd;
	int n_fail = 0, checked = 0, seed = 32'h8E29ED92;
	pss_sequencer #(.FILT_UNIT_CYC(2)) u_dut (.clk_sys, .sys_rst, .forwardStartIn(fwd),
		.reverseStartIn(rev), .pauseResumeIn(pau), .dataStrobeIn(data_strobe_in),
		.autoManualSelectIn(autoSel), .profileSelectIn(psel), .tableNumberIn(tnum),
		.bcdDataIn(bcd), .bcdSignIn(sgn), .functionSelectParam(fsel),
		.commandSystemParam(csys), .directionSelectParam(dir), .jogSpeedParam(jogSpd),
		.inputFilterParam(filt), .motionDoneIn(done), .motionStoppedIn(stopped),
		.cmdOut(cmd), .busyOut(busy), .pausedOut(paused), .autoModeOut(autoM),
		.tableNumberOut(tnumOut));
	pss_motion_model u_core (.clk_sys, .sys_rst, .cmdIn(cmd), .moveLen,
		.motionDoneIn(done), .motionStoppedIn(stopped));
	initial
	begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic report_and_stop;
		$display("fails %0d, checks %0d", n_fail, checked);
		if (n_fail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'h1)
		begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	function automatic logic sel(input int s);
		case (s)
			0: return cmd.startPulse;
			1: return cmd.pausePulse;
			2: return cmd.resumePulse;
			3: return cmd.discardPulse;
			4: return cmd.jogRun;
			5: return paused;
			default: return !busy;
		endcase
	endfunction : sel
	// Bounded wait; a required event that never comes ends the run
	task automatic wt(input int s, input int n, input logic must);
		hit = 1'h0;
		for (int i = 0; i < n && hit !== 1'h1; i++)
		begin
			@(posedge clk_sys);
			#1;
			hit = sel(s);
		end
		if (must && hit !== 1'h1)
		begin
			chk(1'h0, "wait ran out");
			report_and_stop();
		end
	endtask : wt
	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : hold
	task automatic start(input logic useRev, input logic [3:0] ps, input logic expOk);
		logic [23:0] d;
		logic s;
		for (int i = 0; i < 6; i++)
			d[i*4 +: 4] = 4'($unsigned($random(seed)) % 10);
		s = 1'($random(seed));
		@(posedge clk_sys);
		bcd <= d;
		sgn <= s;
		psel <= ps;
		data_strobe_in <= 1'h1;
		hold(12);
		data_strobe_in <= 1'h0;
		bcd <= ~d;
		if (useRev)
			rev <= 1'h1;
		else
			fwd <= 1'h1;
		wt(0, 5, 1'h0);
		chk(!hit, "start before filter delay");
		wt(0, 40, expOk);
		if (expOk)
		begin
			chk(cmd.distanceBcd === d && cmd.tableSel === ps, "data or table");
			chk(cmd.negative === (fsel[11:8] == 4'h1 && s), "sign");
			chk(cmd.absolute === (csys[3:0] == 4'h0), "command system");
			chk(cmd.ccw === (useRev ? dir : !dir), "direction");
			chk(tnumOut === tnum && autoM === 1'h1, "table number in auto");
		end
		hold(1);
		fwd <= 1'h0;
		rev <= 1'h0;
	endtask : start
	task automatic pauseHit(input int s);
		@(posedge clk_sys);
		pau <= 1'h1;
		wt(s, 40, 1'h1);
		hold(12);
		pau <= 1'h0;
		hold(12);
	endtask : pauseHit
	initial
	begin
		hold(12);
		sys_rst <= 1'h0;
		hold(2);
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk_sys);
			csys <= {15'h0, k[0]};
			dir <= k[1];
			fsel[11:8] <= {3'h0, k[2]};
			tnum <= 8'($random(seed));
			filt <= {3'h0, k[2]} + 4'h1;
			start(k[0] & k[1], k[2] ? 4'($unsigned($random(seed)) % 15 + 1) : {k[0], 3'h7}, 1'h1);
			wt(6, 200, 1'h1);
		end
		@(posedge clk_sys);
		csys <= 16'h0000;
		start(1'h1, 4'h3, 1'h0);
		chk(!hit, "reverse taken in absolute");
		start(1'h0, 4'h0, 1'h0);
		chk(!hit, "select zero taken");
		fsel[3:0] <= 4'h1;
		start(1'h0, 4'h5, 1'h0);
		chk(!hit, "start outside BCD system");
		fsel[3:0] <= 4'h2;
		moveLen <= 16'h0190;
		start(1'h0, 4'h7, 1'h1);
		pauseHit(1);
		wt(5, 40, 1'h1);
		start(1'h0, 4'h2, 1'h0);
		chk(!hit, "start taken while paused");
		chk(cmd.tableSel === 4'h7, "table changed after start");
		pauseHit(2);
		pauseHit(1);
		wt(5, 40, 1'h1);
		@(posedge clk_sys);
		autoSel <= 1'h0;
		wt(3, 40, 1'h1);
		wt(6, 40, 1'h1);
		@(posedge clk_sys);
		fwd <= 1'h1;
		wt(4, 40, 1'h1);
		chk(cmd.tableSel === 4'h1 && cmd.jogSpeed === jogSpd && cmd.ccw === !dir, "jog");
		chk(cmd.speedFromJog === 1'h1, "jog speed source");
		chk(tnumOut === 8'h00 && autoM === 1'h0, "table number in manual");
		@(posedge clk_sys);
		pau <= 1'h1;
		hold(20);
		chk(cmd.jogRun === 1'h1 && paused === 1'h0, "pause acted in jog");
		fwd <= 1'h0;
		pau <= 1'h0;
		wt(6, 40, 1'h1);
		report_and_stop();
	end
endmodule : tb
